/* hw/counter_channel_debounce.sv */
// Counter input channel: debounce front end, counter core, timing modes
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/10ps

// ------------------------------------------------------------------
// One input: inverter, synchroniser, debounce filter
// ------------------------------------------------------------------
module deb_filter
  import counter_channel_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 raw,
  input  wire logic                 invert,
  input  wire deb_mode_t            mode,
  input  wire logic [DEB_CNT_W-1:0] stable_cyc,
  output logic                      filt
);
  logic                 sync1_reg;
  logic                 sync2_reg;
  logic                 prev_reg;
  logic [DEB_CNT_W-1:0] run_reg;
  logic                 held_ok;

  // Inverter then two-stage synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= raw ^ invert;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // Cycles the input has held its level, saturating
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_reg <= '0;
    end else if (sync2_reg != prev_reg) begin
      run_reg <= '0;
    end else if (run_reg != {DEB_CNT_W{1'b1}}) begin
      run_reg <= run_reg + 1'b1;
    end
  end

  // Level held for the interval, counting the current cycle
  assign held_ok = (run_reg + 1'b1) >= stable_cyc;

  // Filter output per mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      filt <= 1'b0;
    end else begin
      unique case (mode)
        DEB_BYPASS: filt <= sync2_reg;
        DEB_AFTER: begin
          if (sync2_reg == prev_reg && sync2_reg != filt && held_ok) begin
            filt <= sync2_reg;
          end
        end
        DEB_BEFORE: begin
          if (sync2_reg != prev_reg) begin
            if (held_ok && sync2_reg != filt) begin
              filt <= sync2_reg;
            end
          end else if (held_ok && sync2_reg != filt) begin
            filt <= sync2_reg; // Catch up once quiet
          end
        end
        default: filt <= sync2_reg;
      endcase
    end
  end
endmodule

// ------------------------------------------------------------------
// Channel top
// ------------------------------------------------------------------
module counter_channel_debounce
  import counter_channel_pkg::*;
#(
  parameter int unsigned DEB_DIV = 1
)(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              phase_a,
  input  wire logic              phase_b,
  input  wire logic              index_in,
  input  wire logic              start_of_scan,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic [31:0]            rdata
);
  logic [15:0]          ctrl_reg;
  logic [8:0]           deb_reg;
  logic [31:0]          limit_reg;
  logic [31:0]          count_reg;
  logic [31:0]          count_next;
  logic                 off_reg;
  logic                 off_next;
  logic [31:0]          hold_reg;
  logic [31:0]          scan_reg;
  logic                 first_reg;
  logic [31:0]          result_reg;
  logic [31:0]          meas_reg;
  logic                 run_reg;
  logic [9:0]           per_reg;
  logic [PRE_W-1:0]     pre_reg;
  logic                 a_f;
  logic                 b_f;
  logic                 i_f;
  logic                 a_q;
  logic                 i_q;
  logic [DEB_CNT_W-1:0] deb_tab [DEB_SEL_N];
  logic [DEB_CNT_W-1:0] deb_cyc;
  meas_mode_t           mode;
  idx_mode_t            idx_mode;
  deb_mode_t            deb_mode;
  logic                 a_rise;
  logic                 a_fall;
  logic                 i_rise;
  logic                 i_fall;
  logic                 idx_ev;
  logic                 sw_clear;
  logic                 clear;
  logic                 up;
  logic                 gate_ok;
  logic                 tick;
  logic                 a_start;
  logic                 stop_ev;
  logic [31:0]          meas_max;
  logic [9:0]           per_last;

  // Field decode
  assign mode     = meas_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  assign idx_mode = idx_mode_t'(ctrl_reg[CTRL_IDX_LSB +: 3]);
  assign deb_mode = deb_mode_t'(deb_reg[DEB_MODE_LSB +: 2]);
  assign sw_clear = wr_en && addr == REG_CMD && wdata[CMD_CLEAR];

  // Debounce interval table in clock cycles
  for (genvar g = 0; g < DEB_SEL_N; g++) begin : g_deb
    assign deb_tab[g] = DEB_CNT_W'(deb_cycles(DEB_TIME_NS[g], DEB_DIV));
  end
  assign deb_cyc = deb_tab[deb_reg[DEB_TIME_LSB +: 4]];

  deb_filter u_deb_a (.clk(clk), .reset_n(reset_n), .raw(phase_a), .invert(deb_reg[DEB_INV_A]),
    .mode(deb_mode), .stable_cyc(deb_cyc), .filt(a_f));
  deb_filter u_deb_b (.clk(clk), .reset_n(reset_n), .raw(phase_b), .invert(deb_reg[DEB_INV_B]),
    .mode(deb_mode), .stable_cyc(deb_cyc), .filt(b_f));
  deb_filter u_deb_i (.clk(clk), .reset_n(reset_n), .raw(index_in), .invert(deb_reg[DEB_INV_I]),
    .mode(deb_mode), .stable_cyc(deb_cyc), .filt(i_f));

  // Edge detection on filtered signals
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      a_q <= 1'b0;
      i_q <= 1'b0;
    end else begin
      a_q <= a_f;
      i_q <= i_f;
    end
  end
  assign a_rise = a_f & ~a_q;
  assign a_fall = ~a_f & a_q;
  assign i_rise = i_f & ~i_q;
  assign i_fall = ~i_f & i_q;
  assign idx_ev = ctrl_reg[CTRL_I_POL] ? i_rise : i_fall;
  assign clear  = sw_clear || (idx_ev && idx_mode == IDX_CLEAR);

  // Configuration registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg  <= CTRL_RESET;
      deb_reg   <= DEB_RESET;
      limit_reg <= LIMIT_RESET;
    end else if (wr_en) begin
      if (addr == REG_CTRL) ctrl_reg <= wdata[15:0];
      if (addr == REG_DEB) deb_reg <= wdata[8:0];
      if (addr == REG_LIMIT) limit_reg <= wdata;
    end
  end

  // Next count for the event counter
  always_comb begin
    count_next = count_reg;
    off_next   = off_reg;
    up         = !ctrl_reg[CTRL_UPDOWN] || b_f;
    gate_ok    = idx_mode != IDX_GATE || i_f;
    if (mode == MODE_COUNT && a_rise && gate_ok && !off_reg) begin
      if (up) begin
        if (ctrl_reg[CTRL_RANGE] && count_reg == limit_reg) begin
          count_next = count_reg;
        end else if (ctrl_reg[CTRL_NONREC] && count_reg == 32'hffffffff) begin
          off_next = 1'b1;
        end else if (!ctrl_reg[CTRL_RANGE] && !ctrl_reg[CTRL_NONREC]
                     && count_reg == limit_reg) begin
          count_next = 32'h00000000;
        end else begin
          count_next = count_reg + 32'h00000001;
          if (ctrl_reg[CTRL_NONREC] && count_next == limit_reg) off_next = 1'b1;
        end
      end else if (count_reg == 32'h00000000) begin
        if (ctrl_reg[CTRL_NONREC]) off_next = 1'b1;
        else if (!ctrl_reg[CTRL_RANGE]) count_next = limit_reg;
      end else begin
        count_next = count_reg - 32'h00000001;
      end
    end
    if (mode == MODE_COUNT && idx_ev && idx_mode == IDX_DEC) begin
      count_next = count_next - 32'h00000001;
    end
    if (start_of_scan && (first_reg || ctrl_reg[CTRL_CLR_RD])) begin
      count_next = 32'h00000000;
    end
    if (clear) begin
      count_next = 32'h00000000;
      off_next   = 1'b0;
    end
  end

  // Counter state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
      off_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      off_reg   <= off_next;
    end
  end

  // Index latch into the hold register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_reg <= '0;
    end else if (idx_ev && idx_mode == IDX_LATCH) begin
      hold_reg <= count_reg;
    end
  end

  // Scan capture; first scan reports zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_reg  <= '0;
      first_reg <= 1'b1;
    end else if (start_of_scan) begin
      first_reg <= 1'b0;
      if (first_reg) scan_reg <= 32'h00000000;
      else if (mode == MODE_COUNT) scan_reg <= count_reg;
      else scan_reg <= result_reg;
    end
  end

  // Tick prescaler for timing modes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_reg <= '0;
    end else if (tick) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end
  assign tick = pre_reg == PRE_W'(TICK_DIV[ctrl_reg[CTRL_TICK_LSB +: 2]] - 1);

  // Measurement start and stop events
  assign a_start  = ctrl_reg[CTRL_A_POL] ? a_rise : a_fall;
  assign meas_max = ctrl_reg[CTRL_WIDE] ? 32'hffffffff : 32'h0000ffff;
  assign per_last = 10'(PERIOD_N[ctrl_reg[CTRL_PER_LSB +: 2]] - 1);
  always_comb begin
    unique case (mode)
      MODE_PULSE:  stop_ev = ctrl_reg[CTRL_A_POL] ? a_fall : a_rise;
      MODE_TIMING: stop_ev = idx_ev;
      default:     stop_ev = 1'b0;
    endcase
  end

  // Period, pulse width and edge-to-edge timer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meas_reg   <= '0;
      run_reg    <= 1'b0;
      per_reg    <= '0;
      result_reg <= '0;
    end else if (clear || mode == MODE_COUNT) begin
      meas_reg <= '0;
      run_reg  <= 1'b0;
      per_reg  <= '0;
    end else if (mode == MODE_PERIOD) begin
      if (a_rise && !run_reg) begin
        run_reg  <= 1'b1;
        meas_reg <= '0;
        per_reg  <= '0;
      end else if (a_rise && per_reg == per_last) begin
        result_reg <= (tick && meas_reg < meas_max) ? meas_reg + 32'h00000001 : meas_reg;
        meas_reg   <= '0;
        per_reg    <= '0;
      end else begin
        if (a_rise) per_reg <= per_reg + 10'h001;
        if (tick && run_reg && meas_reg < meas_max) meas_reg <= meas_reg + 32'h00000001;
      end
    end else begin
      if (a_start && !run_reg) begin
        run_reg  <= 1'b1;
        meas_reg <= '0;
      end else if (stop_ev && run_reg) begin
        run_reg    <= 1'b0;
        result_reg <= (tick && meas_reg < meas_max) ? meas_reg + 32'h00000001 : meas_reg;
      end else if (tick && run_reg && meas_reg < meas_max) begin
        meas_reg <= meas_reg + 32'h00000001;
      end
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else if (rd_en) begin
      case (addr)
        REG_CTRL:  rdata <= {16'h0000, ctrl_reg};
        REG_DEB:   rdata <= {23'h000000, deb_reg};
        REG_LIMIT: rdata <= limit_reg;
        REG_SCAN:  rdata <= scan_reg;
        REG_HOLD:  rdata <= hold_reg;
        REG_LIVE:  rdata <= (mode == MODE_COUNT) ? count_reg : result_reg;
        REG_STAT:  rdata <= {29'h00000000, first_reg, run_reg, off_reg};
        default:   rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule

/* hw/counter_channel_pkg.sv */
// Constants, register map and types for one counter input channel
package counter_channel_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 10_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int DEB_CNT_W     = 24;
  localparam int DEB_SEL_N     = 16;
  // Debounce interval choices in ns, 500 ns to 25.5 ms
  localparam int unsigned DEB_TIME_NS [DEB_SEL_N] = '{
    500, 1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000, 500000,
    1000000, 2000000, 5000000, 10000000, 20000000, 25500000};
  // Periods summed into one result and tick dividers, selected by two bits each
  localparam int unsigned PERIOD_N [4] = '{1, 10, 100, 1000};
  localparam int unsigned TICK_DIV [4] = '{1, 10, 100, 1000};
  localparam int PRE_W = 10;

  // Least stable time in cycles, rounded up, then divided by div rounding down, never below one
  function automatic int unsigned deb_cycles(int unsigned ns, int unsigned div);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS / div;
    return (c < 1) ? 1 : c;
  endfunction

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] REG_CTRL  = 5'h00;
  localparam logic [4:0] REG_DEB   = 5'h04;
  localparam logic [4:0] REG_LIMIT = 5'h08;
  localparam logic [4:0] REG_CMD   = 5'h0c;
  localparam logic [4:0] REG_SCAN  = 5'h10;
  localparam logic [4:0] REG_HOLD  = 5'h14;
  localparam logic [4:0] REG_LIVE  = 5'h18;
  localparam logic [4:0] REG_STAT  = 5'h1c;

  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [8:0]  DEB_RESET   = 9'h000;
  localparam logic [31:0] LIMIT_RESET = 32'hffffffff;

  // Control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CLR_RD   = 2;
  localparam int CTRL_RANGE    = 3;
  localparam int CTRL_NONREC   = 4;
  localparam int CTRL_UPDOWN   = 5;
  localparam int CTRL_IDX_LSB  = 6;
  localparam int CTRL_PER_LSB  = 9;
  localparam int CTRL_WIDE     = 11;
  localparam int CTRL_TICK_LSB = 12;
  localparam int CTRL_A_POL    = 14;
  localparam int CTRL_I_POL    = 15;
  // Debounce and command field positions
  localparam int DEB_TIME_LSB = 0;
  localparam int DEB_MODE_LSB = 4;
  localparam int DEB_INV_A    = 6;
  localparam int DEB_INV_B    = 7;
  localparam int DEB_INV_I    = 8;
  localparam int CMD_CLEAR    = 0;

  typedef enum logic [1:0] {MODE_COUNT, MODE_PERIOD, MODE_PULSE, MODE_TIMING} meas_mode_t;
  typedef enum logic [2:0] {IDX_NONE, IDX_GATE, IDX_LATCH, IDX_DEC, IDX_CLEAR} idx_mode_t;
  typedef enum logic [1:0] {DEB_BYPASS, DEB_AFTER, DEB_BEFORE} deb_mode_t;

endpackage

/* verification/pulse_source.sv */
// Pulse, direction and index source facing the channel inputs
`timescale 1ns/10ps
module pulse_source (
  input  wire logic clk,
  output logic      phase_a,
  output logic      phase_b,
  output logic      index_in
);
  // Idle levels at time zero
  initial begin
    phase_a = 1'h0;
    phase_b = 1'h1;
    index_in = 1'h0;
  end
  // Hold phase A at a level for n cycles
  task automatic level(input logic v, input int n);
    @(posedge clk);
    phase_a <= v;
    repeat (n - 1) @(posedge clk);
  endtask
  // Pulses two cycles high, two low, then settle
  task automatic pulses(input int n);
    repeat (n) begin
      level(1'h1, 2);
      level(1'h0, 2);
    end
    repeat (4) @(posedge clk);
  endtask
  // Direction level for up/down counting
  task automatic set_b(input logic v);
    @(posedge clk);
    phase_b <= v;
  endtask
  // Index high six cycles, low six
  task automatic ipulse();
    @(posedge clk);
    index_in <= 1'h1;
    repeat (6) @(posedge clk);
    index_in <= 1'h0;
    repeat (6) @(posedge clk);
  endtask
  // Index level change and settle
  task automatic set_i(input logic v);
    @(posedge clk);
    index_in <= v;
    repeat (4) @(posedge clk);
  endtask
endmodule

/* verification/counter_channel_checker.sv */
// Port-level assertions for the counter channel
`timescale 1ns/10ps
module counter_channel_checker
  import counter_channel_pkg::*;
#(
  parameter int unsigned DEB_DIV = 1
)(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              phase_a,
  input wire logic              phase_b,
  input wire logic              index_in,
  input wire logic              start_of_scan,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0]       wdata,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [31:0]       rdata
);
  logic [15:0] ctl_reg;
  logic [31:0] lim_reg;
  logic [1:0]  scans_reg;
  logic [3:0]  ist_reg;
  logic        iq_reg;
  logic        rq_reg;
  logic        dis_reg;
  logic        rl;
  logic        cm;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  assign rl = rd_en && addr == REG_LIVE;
  assign cm = ctl_reg[1:0] == 2'h0;
  // Shadows of control and limit writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_reg <= CTRL_RESET;
      lim_reg <= LIMIT_RESET;
    end else if (wr_en && addr == REG_CTRL) begin
      ctl_reg <= wdata[15:0];
    end else if (wr_en && addr == REG_LIMIT) begin
      lim_reg <= wdata;
    end
  end
  // Scan count, index stability, seen-disabled flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scans_reg <= 2'h0;
      ist_reg <= 4'h0;
      iq_reg <= 1'h0;
      rq_reg <= 1'h0;
      dis_reg <= 1'h0;
    end else begin
      if (start_of_scan && scans_reg != 2'h3)
        scans_reg <= scans_reg + 2'h1;
      iq_reg <= index_in;
      ist_reg <= (index_in != iq_reg) ? 4'h0 : ist_reg + {3'h0, ist_reg != 4'hf};
      rq_reg <= rd_en && addr == REG_STAT;
      if ((wr_en && addr == REG_CMD && wdata[0]) || ctl_reg[8:6] == 3'h4)
        dis_reg <= 1'h0;
      else if (rq_reg && rdata[0])
        dis_reg <= 1'h1;
    end
  end
  first_scan_a: assert property (rd_en && addr == REG_SCAN && scans_reg < 2'h2
    && !start_of_scan |=> rdata == 32'h0) else $error("scan value not zero");
  stat_first_a: assert property (rd_en && addr == REG_STAT && scans_reg == 2'h0
    && !start_of_scan |=> rdata[2]) else $error("no-scan flag low");
  range_top_a: assert property (rl && cm && ctl_reg[3] |=> rdata <= lim_reg)
    else $error("range count above limit");
  nonrec_top_a: assert property (rl && cm && ctl_reg[4] |=> rdata <= lim_reg)
    else $error("non-recycle count above limit");
  clr_read_a: assert property (start_of_scan && cm && ctl_reg[2] && ctl_reg[8:6] == 3'h0
    ##2 rl |=> rdata <= 32'h1) else $error("count not cleared by scan");
  dis_hold_a: assert property (rd_en && addr == REG_STAT && dis_reg |=> rdata[0])
    else $error("disable dropped without clear");
  hold_keep_a: assert property (rd_en && addr == REG_HOLD && ist_reg == 4'hf ##2
    rd_en && addr == REG_HOLD && ist_reg == 4'hf |=> rdata == $past(rdata, 2))
    else $error("hold changed without index event");
  gate_keep_a: assert property (rl && ctl_reg[8:6] == 3'h1 && !index_in && ist_reg == 4'hf
    ##2 rl && ist_reg == 4'hf |=> rdata == $past(rdata, 2)) else $error("gated count moved");
  cover property (rl && ctl_reg[3]);
  cover property (rd_en && addr == REG_STAT && dis_reg);
  cover property (start_of_scan && scans_reg == 2'h1);
endmodule

bind counter_channel_debounce counter_channel_checker #(.DEB_DIV(DEB_DIV)) chk (
  .clk           (clk),
  .reset_n       (reset_n),
  .phase_a       (phase_a),
  .phase_b       (phase_b),
  .index_in      (index_in),
  .start_of_scan (start_of_scan),
  .addr          (addr),
  .wdata         (wdata),
  .wr_en         (wr_en),
  .rd_en         (rd_en),
  .rdata         (rdata)
);

/* verification/tb.sv */
// Self-checking bench for the counter channel
`timescale 1ns/10ps
module tb;
  import counter_channel_pkg::*;
  logic              clk = 1'h0;
  logic              reset_n;
  logic              start_of_scan;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       wdata;
  logic              wr_en;
  logic              rd_en;
  logic [31:0]       rdata;
  logic              phase_a;
  logic              phase_b;
  logic              index_in;
  logic [31:0]       v;
  int                miscompares = 0;
  int                num_checks = 0;
  always #50 clk = ~clk;
  pulse_source src (
    .clk      (clk),
    .phase_a  (phase_a),
    .phase_b  (phase_b),
    .index_in (index_in)
  );
  counter_channel_debounce #(
    .DEB_DIV (1000)
  ) DUT (
    .clk           (clk),
    .reset_n       (reset_n),
    .phase_a       (phase_a),
    .phase_b       (phase_b),
    .index_in      (index_in),
    .start_of_scan (start_of_scan),
    .addr          (addr),
    .wdata         (wdata),
    .wr_en         (wr_en),
    .rd_en         (rd_en),
    .rdata         (rdata)
  );
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1 v = rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    rd(a);
    chk(v, exp);
  endtask
  task automatic cfg(input logic [31:0] c, input logic [31:0] d);
    wr(REG_CTRL, c);
    wr(REG_DEB, d);
    wr(REG_CMD, 32'h1);
  endtask
  task automatic scan();
    @(posedge clk);
    start_of_scan <= 1'h1;
    @(posedge clk);
    start_of_scan <= 1'h0;
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rc(REG_DEB, 32'h0);
    rc(REG_LIMIT, LIMIT_RESET);
    rc(REG_STAT, 32'h4);
    wr(REG_SCAN, 32'h5a5a);
    rc(REG_SCAN, 32'h0);
    rc(5'h02, 32'h0);
    $display("%0t reset test done", $time);
  endtask
  task automatic t_scan();
    src.pulses(3);
    scan();
    rc(REG_SCAN, 32'h0);
    src.pulses(5);
    scan();
    rc(REG_SCAN, 32'h5);
    cfg(32'h4, 32'h0);
    src.pulses(4);
    scan();
    rc(REG_LIVE, 32'h0);
    rc(REG_SCAN, 32'h4);
    $display("%0t scan test done", $time);
  endtask
  task automatic t_range();
    cfg(32'h28, 32'h0);
    wr(REG_LIMIT, 32'h5);
    src.pulses(8);
    rc(REG_LIVE, 32'h5);
    src.set_b(1'h0);
    src.pulses(2);
    rc(REG_LIVE, 32'h3);
    src.pulses(6);
    rc(REG_LIVE, 32'h0);
    src.set_b(1'h1);
    src.pulses(1);
    rc(REG_LIVE, 32'h1);
    $display("%0t range test done", $time);
  endtask
  task automatic t_nonrec();
    cfg(32'h10, 32'h0);
    wr(REG_LIMIT, 32'h3);
    src.pulses(5);
    rc(REG_LIVE, 32'h3);
    rd(REG_STAT);
    chk(v & 32'h1, 32'h1);
    src.pulses(2);
    rc(REG_LIVE, 32'h3);
    rc(REG_STAT, 32'h1);
    wr(REG_CMD, 32'h1);
    src.pulses(1);
    rc(REG_LIVE, 32'h1);
    cfg(32'h8110, 32'h0);
    src.pulses(4);
    rc(REG_LIVE, 32'h3);
    src.ipulse();
    src.pulses(1);
    rc(REG_LIVE, 32'h1);
    $display("%0t non-recycle test done", $time);
  endtask
  task automatic t_index();
    cfg(32'h40, 32'h0);
    src.pulses(3);
    rc(REG_LIVE, 32'h0);
    rc(REG_LIVE, 32'h0);
    src.set_i(1'h1);
    src.pulses(3);
    rc(REG_LIVE, 32'h3);
    src.set_i(1'h0);
    cfg(32'h8080, 32'h0);
    src.pulses(2);
    src.ipulse();
    src.pulses(1);
    rc(REG_LIVE, 32'h3);
    rc(REG_HOLD, 32'h2);
    rc(REG_HOLD, 32'h2);
    wr(REG_CTRL, 32'h80c0);
    src.ipulse();
    rc(REG_LIVE, 32'h2);
    $display("%0t index test done", $time);
  endtask
  task automatic t_deb();
    int n;
    n = ((DEB_TIME_NS[10] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) / 1000;
    cfg(32'h0, 32'h1a);
    src.level(1'h1, n - 3);
    src.level(1'h0, n + 4);
    src.level(1'h1, n + 3);
    src.level(1'h0, n + 4);
    rc(REG_LIVE, 32'h1);
    cfg(32'h0, 32'h2a);
    repeat (3) begin
      src.level(1'h1, 1);
      src.level(1'h0, 1);
    end
    src.level(1'h0, n - 5);
    src.level(1'h1, 2);
    src.level(1'h0, n + 4);
    rc(REG_LIVE, 32'h1);
    src.level(1'h1, 2);
    src.level(1'h0, n + 4);
    rc(REG_LIVE, 32'h2);
    cfg(32'h0, 32'h0f);
    src.pulses(1);
    rc(REG_LIVE, 32'h1);
    wr(REG_DEB, 32'h4f);
    src.pulses(1);
    rc(REG_LIVE, 32'h3);
    $display("%0t debounce test done", $time);
  endtask
  task automatic t_meas();
    cfg(32'h4001, 32'h0);
    src.pulses(2);
    rc(REG_LIVE, 32'h4);
    cfg(32'h4a01, 32'h0);
    src.pulses(11);
    rc(REG_LIVE, 32'h28);
    cfg(32'h4002, 32'h0);
    src.level(1'h1, 6);
    src.level(1'h0, 6);
    rc(REG_LIVE, 32'h6);
    cfg(32'hc003, 32'h0);
    src.level(1'h1, 5);
    src.ipulse();
    src.level(1'h0, 4);
    rc(REG_LIVE, 32'h5);
    $display("%0t measure test done", $time);
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    final_report();
  end
  // Main sequence
  initial begin
    reset_n = 1'h0;
    start_of_scan = 1'h0;
    addr = 5'h00;
    wdata = 32'h00000000;
    wr_en = 1'h0;
    rd_en = 1'h0;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    t_reset();
    t_scan();
    t_range();
    t_nonrec();
    t_index();
    t_deb();
    t_meas();
    final_report();
  end
endmodule
